// File: hdl/hbw_host_port.sv
// module: host microprocessor port with ready / data-acknowledge waits
// Summary of operation
// - waits counted in two-clock slow cycles
// - write waits: none, 5-7, 9-29 slow
// - read waits: none, 6-7, 9-33 slow
// - excess data RAM access stretches to 97
// - motorola select is select OR lower strobe
// - motorola read: ack high slow, low register
// - ack driven from select fall, floats after
// - intel ready high on select, low waiting
// - motorola read data driven, valid at ack
// - 11-bit address, 8-bit data, floated after
// - motorola write: ack high slow, low register
// - intel slow read data valid at ready
module hbw_host_port
  import hbw_pkg::*;
#(
  parameter int FRAME_CLKS_P = FRAME_CLKS
) (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic MOTO_MODE_I,
  input wire logic SEL_N_I,
  input wire logic RD_N_I,
  input wire logic WR_N_I,
  input wire logic LOWER_STROBE_N_I,
  input wire logic RW_I,
  input wire logic [10:0] ADDR_I,
  input wire logic [7:0] DATA_I,
  output logic [7:0] DATA_O,
  output logic DATA_OE_N_O,
  output logic RDY_O,
  output logic RDY_OE_N_O,
  output logic DATA_ACK_N_O,
  output logic DATA_ACK_OE_N_O,
  output logic USR_REQ_O,
  output logic USR_WRITE_O,
  output logic [1:0] USR_TARGET_O,
  output logic [10:0] USR_ADDR_O,
  output logic [7:0] USR_WDATA_O,
  input wire logic USR_ACK_I,
  input wire logic [7:0] USR_RDATA_I
);
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    hbw_state_e state;
    hbw_target_e target;
    logic is_write;
    logic throttle;
    logic req_sent;
    logic port_en;
    logic wait_low;
    logic ack_low;
    logic data_oe;
    logic req;
    logic [10:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [12:0] frame_cnt;
    logic [4:0] dram_cnt;
  } hbw_main_s;

  hbw_main_s r_reg;
  hbw_main_s r_next;
  hbw_timer_if tif ();
  logic moto;
  logic sel;
  logic access;
  logic wr_now;
  hbw_target_e tgt_now;
  logic [15:0] lim;

  hbw_wait_timer u_timer (
    .clk_i(CLOCK_I),
    .rst_n_i(RESET_N_I),
    .tif(tif)
  );

  // =========================================================================
  // decode of the synchronised pins; only the second stage is read
  assign moto = r_reg.s2[PIN_MODE];
  assign sel = !r_reg.s2[PIN_SEL];
  // motorola access is the OR of select and lower strobe, low active
  assign access = moto ? !(r_reg.s2[PIN_SEL] | r_reg.s2[PIN_LDS])
                       : sel && !(r_reg.s2[PIN_RD] && r_reg.s2[PIN_WR]);
  assign wr_now = moto ? !r_reg.s2[PIN_RW] : !r_reg.s2[PIN_WR];
  assign tgt_now = hbw_decode(r_reg.s2[PIN_ADDR_LSB +: 11]);
  assign lim = hbw_limits(r_reg.target, r_reg.is_write, r_reg.throttle);
  assign tif.min_clks = lim[15:8];
  assign tif.max_clks = lim[7:0];
  assign tif.ack = USR_ACK_I && r_reg.req_sent;

  // =========================================================================
  // port engine
  always_comb begin
    r_next = r_reg;
    r_next.s1 = {MOTO_MODE_I, RW_I, LOWER_STROBE_N_I, WR_N_I, RD_N_I, SEL_N_I,
                 DATA_I, ADDR_I};
    r_next.s2 = r_reg.s1;
    r_next.req = 1'b0;
    tif.start = 1'b0;
    // frame window for data RAM pacing
    if (r_reg.frame_cnt >= 13'(FRAME_CLKS_P - 1)) begin
      r_next.frame_cnt = 13'h0000;
      r_next.dram_cnt = 5'h00;
    end else begin
      r_next.frame_cnt = 13'(r_reg.frame_cnt + 13'h0001);
    end
    unique case (r_reg.state)
      ST_IDLE: begin
        if (sel) begin
          r_next.state = ST_SELECTED;
          r_next.port_en = 1'b1;
          r_next.ack_low = 1'b0;
        end
      end
      ST_SELECTED: begin
        if (access) begin
          r_next.addr = r_reg.s2[PIN_ADDR_LSB +: 11];
          r_next.is_write = wr_now;
          r_next.target = tgt_now;
          r_next.data_oe = !wr_now;
          r_next.throttle = (tgt_now == TGT_DRAM) &&
                            (r_reg.dram_cnt >= DRAM_ACCESS_LIMIT);
          // count on top of the window clear so a wrap never loses it
          if (tgt_now == TGT_DRAM && r_next.dram_cnt != 5'h1F) begin
            r_next.dram_cnt = 5'(r_next.dram_cnt + 5'h01);
          end
          if (tgt_now == TGT_REG) begin
            // registers answer at once: no wait, ack low right away
            r_next.state = ST_HOLD;
            r_next.ack_low = 1'b1;
            if (!wr_now) begin
              r_next.req = 1'b1;
              r_next.rdata = USR_RDATA_I;
            end
          end else begin
            // slow target: ready low, ack stays high while waiting
            r_next.state = ST_WAIT;
            r_next.wait_low = 1'b1;
            r_next.req_sent = 1'b0;
            tif.start = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        // write data is only trusted one slow cycle after the strobe
        if (!r_reg.req_sent && (!r_reg.is_write ||
            tif.elapsed >= 8'(SLOW_CYCLE_CLKS))) begin
          r_next.req = 1'b1;
          r_next.req_sent = 1'b1;
          r_next.wdata = r_reg.s2[PIN_DATA_LSB +: 8];
        end
        if (tif.ack && !r_reg.is_write) begin
          r_next.rdata = USR_RDATA_I;
        end
        if (tif.done) begin
          r_next.state = ST_HOLD;
          r_next.wait_low = 1'b0;
          r_next.ack_low = 1'b1;
        end
      end
      ST_HOLD: begin
        if (!access) begin
          // register write takes the data present at the strobe rise
          if (r_reg.is_write && r_reg.target == TGT_REG) begin
            r_next.req = 1'b1;
            r_next.wdata = r_reg.s2[PIN_DATA_LSB +: 8];
          end
          r_next.data_oe = 1'b0;
          r_next.state = ST_FLOAT;
        end
      end
      ST_FLOAT: begin
        // one settling clock before a new strobe is looked at
        r_next.state = ST_SELECTED;
        r_next.ack_low = 1'b0;
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase
    // select removal idles the port and floats its pins; a late engine answer is dropped
    if (!sel) begin
      r_next.state = ST_IDLE;
      r_next.port_en = 1'b0;
      r_next.wait_low = 1'b0;
      r_next.ack_low = 1'b0;
      r_next.data_oe = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      r_reg <= '{s1: PIN_RESET, s2: PIN_RESET, state: ST_IDLE,
                 target: TGT_REG, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // =========================================================================
  // pin and user outputs
  assign DATA_O = r_reg.rdata;
  assign DATA_OE_N_O = !r_reg.data_oe;
  assign RDY_O = !r_reg.wait_low;
  assign RDY_OE_N_O = !(r_reg.port_en && !moto);
  assign DATA_ACK_N_O = !r_reg.ack_low;
  assign DATA_ACK_OE_N_O = !(r_reg.port_en && moto);
  assign USR_REQ_O = r_reg.req;
  assign USR_WRITE_O = r_reg.is_write;
  assign USR_TARGET_O = r_reg.target;
  assign USR_ADDR_O = r_reg.addr;
  assign USR_WDATA_O = r_reg.wdata;

  // =========================================================================
  // checks
  logic [7:0] low_run;
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      low_run <= 8'h00;
    end else begin
      low_run <= r_reg.wait_low ? 8'(low_run + 8'h01) : 8'h00;
    end
  end

  // last word handed back by the engine during the current wait
  logic rd_seen;
  logic [7:0] rd_hold;
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_seen <= 1'b0;
      rd_hold <= 8'h00;
    end else if (tif.start) begin
      rd_seen <= 1'b0;
    end else if (tif.ack) begin
      rd_seen <= 1'b1;
      rd_hold <= USR_RDATA_I;
    end
  end

  sequence wait_end_s;
    $fell(r_reg.wait_low) && sel;
  endsequence

  a_wr_wait_len: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    wait_end_s and r_reg.is_write |-> low_run >= tif.min_clks &&
    low_run <= tif.max_clks && low_run[0] == 1'b0)
    else $error("write wait outside its bounds");
  a_rd_wait_len: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    wait_end_s and !r_reg.is_write |-> low_run >= tif.min_clks &&
    low_run <= tif.max_clks)
    else $error("read wait outside its bounds");
  a_throttle_len: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    wait_end_s and r_reg.throttle |-> low_run == 8'hC2)
    else $error("throttled wait not 97 slow cycles");
  a_reg_no_wait: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    r_reg.state == ST_SELECTED && access && tgt_now == TGT_REG && sel
    |=> !r_reg.wait_low [*2])
    else $error("register access waited");
  a_moto_select: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    r_reg.state == ST_SELECTED && moto &&
    (r_reg.s2[PIN_SEL] || r_reg.s2[PIN_LDS])
    |=> r_reg.state inside {ST_SELECTED, ST_IDLE})
    else $error("access started without both selects");
  a_ack_slow_high: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    moto && r_reg.wait_low |-> !DATA_ACK_OE_N_O && DATA_ACK_N_O)
    else $error("ack low during slow wait");
  a_ports_float: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    !sel |=> DATA_ACK_OE_N_O && RDY_OE_N_O && DATA_OE_N_O)
    else $error("outputs driven after select rose");
  a_rdy_driven: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    $fell(r_reg.s2[PIN_SEL]) && !moto |=> !RDY_OE_N_O && RDY_O)
    else $error("ready not driven high on select");
  a_read_valid: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    wait_end_s and (!r_reg.is_write && rd_seen)
    |-> !DATA_OE_N_O && DATA_O == rd_hold)
    else $error("read data not held at ready rise");
  a_reg_commit: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
    r_reg.state == ST_HOLD && !access && sel && r_reg.is_write &&
    r_reg.target == TGT_REG |=> USR_REQ_O && USR_WRITE_O)
    else $error("register write not committed at strobe rise");
endmodule : hbw_host_port

// File: hdl/hbw_pkg.sv
// package: constants, types and helpers of the host bus wait handshake port
package hbw_pkg;
  // =========================================================================
  // clock and time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int SLOW_CYCLE_CLKS = 2;
  localparam int FRAME_TIME_NS = 125000;
  localparam int FRAME_CLKS = FRAME_TIME_NS / CLK_PERIOD_NS;
  localparam logic [4:0] DRAM_ACCESS_LIMIT = 5'h10;
  // =========================================================================
  // wait limits in slow cycles
  localparam logic [7:0] IMEM_WR_MIN = 8'h05;
  localparam logic [7:0] IMEM_WR_MAX = 8'h07;
  localparam logic [7:0] IMEM_RD_MIN = 8'h06;
  localparam logic [7:0] IMEM_RD_MAX = 8'h07;
  localparam logic [7:0] DRAM_WR_MIN = 8'h09;
  localparam logic [7:0] DRAM_WR_MAX = 8'h1D;
  localparam logic [7:0] DRAM_RD_MIN = 8'h09;
  localparam logic [7:0] DRAM_RD_MAX = 8'h21;
  localparam logic [7:0] THROTTLE_SLOW = 8'h61;
  // =========================================================================
  // synchronised pin vector layout
  localparam int PIN_ADDR_LSB = 0;
  localparam int PIN_DATA_LSB = 11;
  localparam int PIN_SEL = 19;
  localparam int PIN_RD = 20;
  localparam int PIN_WR = 21;
  localparam int PIN_LDS = 22;
  localparam int PIN_RW = 23;
  localparam int PIN_MODE = 24;
  localparam int PIN_W = 25;
  localparam logic [PIN_W-1:0] PIN_RESET = 25'h0F80000;
  // =========================================================================
  // address windows: bits 10:9 pick the target
  localparam logic [1:0] IMEM_WINDOW = 2'h2;
  localparam logic [1:0] DRAM_WINDOW = 2'h3;

  typedef enum logic [1:0] {
    TGT_REG = 2'h0,
    TGT_IMEM = 2'h1,
    TGT_DRAM = 2'h2
  } hbw_target_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SELECTED = 5'h02,
    ST_WAIT = 5'h04,
    ST_HOLD = 5'h08,
    ST_FLOAT = 5'h10
  } hbw_state_e;

  // map an address onto its target
  function automatic hbw_target_e hbw_decode(input logic [10:0] addr);
    if (addr[10:9] == IMEM_WINDOW) begin
      return TGT_IMEM;
    end else if (addr[10:9] == DRAM_WINDOW) begin
      return TGT_DRAM;
    end
    return TGT_REG;
  endfunction : hbw_decode

  // slow cycles to core clocks
  function automatic logic [7:0] hbw_clks(input logic [7:0] slow);
    return 8'(slow * SLOW_CYCLE_CLKS);
  endfunction : hbw_clks

  // wait bounds {min, max} in core clocks
  function automatic logic [15:0] hbw_limits(input hbw_target_e tgt,
                                             input logic wr,
                                             input logic thr);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = 8'h00;
    hi = 8'h00;
    if (tgt == TGT_IMEM) begin
      lo = wr ? IMEM_WR_MIN : IMEM_RD_MIN;
      hi = wr ? IMEM_WR_MAX : IMEM_RD_MAX;
    end else if (tgt == TGT_DRAM) begin
      lo = thr ? THROTTLE_SLOW : (wr ? DRAM_WR_MIN : DRAM_RD_MIN);
      hi = thr ? THROTTLE_SLOW : (wr ? DRAM_WR_MAX : DRAM_RD_MAX);
    end
    return {hbw_clks(lo), hbw_clks(hi)};
  endfunction : hbw_limits
endpackage : hbw_pkg

// File: hdl/hbw_timer_if.sv
// interface: wait timer control between the port engine and its timer
interface hbw_timer_if;
  logic start;
  logic [7:0] min_clks;
  logic [7:0] max_clks;
  logic ack;
  logic done;
  logic [7:0] elapsed;
  modport ctrl (output start, output min_clks, output max_clks, output ack,
                input done, input elapsed);
  modport timer (input start, input min_clks, input max_clks, input ack,
                 output done, output elapsed);
endinterface : hbw_timer_if

// File: hdl/hbw_wait_timer.sv
// module: counts one host wait, bounded below and above, ended by the ack
module hbw_wait_timer
  import hbw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  hbw_timer_if.timer tif
);
  typedef struct packed {
    logic busy;
    logic ack_seen;
    logic [7:0] count;
  } hbw_tmr_s;

  hbw_tmr_s t_reg;
  hbw_tmr_s t_next;
  logic done;

  // =========================================================================
  // done once the floor is passed and the engine answered, or at the ceiling;
  // an early end only on an even count so every wait is whole slow cycles
  assign done = t_reg.busy && ((t_reg.count >= tif.min_clks &&
                !t_reg.count[0] && (t_reg.ack_seen || tif.ack)) ||
                t_reg.count >= tif.max_clks);
  assign tif.done = done;
  assign tif.elapsed = t_reg.count;

  // count starts at one so the wait lasts exactly count clocks
  always_comb begin
    t_next = t_reg;
    if (tif.start) begin
      t_next.busy = 1'b1;
      t_next.ack_seen = 1'b0;
      t_next.count = 8'h01;
    end else if (t_reg.busy) begin
      t_next.ack_seen = t_reg.ack_seen | tif.ack;
      if (done) begin
        t_next.busy = 1'b0;
      end else begin
        t_next.count = 8'(t_reg.count + 8'h01);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end
endmodule : hbw_wait_timer

// File: sim/hbw_host_model.sv
// host microprocessor model driving the intel and motorola pin sets
module hbw_host_model (
  input wire logic clk_i,
  output logic moto_o,
  output logic sel_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic strobe_n_o,
  output logic rw_o,
  output logic [10:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic data_oe_n_i,
  input wire logic rdy_i,
  input wire logic rdy_oe_n_i,
  input wire logic ack_n_i,
  input wire logic ack_oe_n_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // =========================================================================
  // idle bus: nothing selected, strobes high
  initial begin
    moto_o = 1'b0;
    sel_n_o = 1'b1;
    {rd_n_o, wr_n_o, strobe_n_o} = 3'h7;
    rw_o = 1'b1;
    addr_o = 11'h000;
    wdata_o = 8'h00;
  end
  // one access; waitc counts held cycles, oe packs the enables seen
  task automatic access(input logic wr, input logic [10:0] addr,
                        input logic [7:0] wd, output logic [7:0] rd,
                        output int waitc, output logic [3:0] oe);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    waitc = 0;
    oe = 4'hF;
    @(negedge clk_i);
    addr_o = addr;
    rw_o = ~wr;
    // a released bus never shows the last value, so reads invert it
    wdata_o = wr ? wd : ~wdata_o;
    sel_n_o = 1'b0;
    @(negedge clk_i);
    strobe_n_o = ~moto_o;
    wr_n_o = moto_o | ~wr;
    rd_n_o = moto_o | wr;
    // follow the handshake pin, bounded so a dead port cannot hang us
    while (!done && n < 300) begin
      @(posedge clk_i);
      #1;
      n++;
      if (moto_o) begin
        waitc += int'(ack_oe_n_i === 1'b0 && ack_n_i === 1'b1);
        done = ack_oe_n_i === 1'b0 && ack_n_i === 1'b0;
      end else begin
        waitc += int'(rdy_i === 1'b0);
        done = rdy_i === 1'b1 && (waitc > 0 || n > 8);
      end
    end
    rd = rdata_i;
    oe[0] = moto_o ? ack_oe_n_i : rdy_oe_n_i;
    oe[3] = data_oe_n_i;
    @(negedge clk_i);
    {rd_n_o, wr_n_o, strobe_n_o} = 3'h7;
    repeat (5) @(negedge clk_i);
    oe[1] = data_oe_n_i;
    sel_n_o = 1'b1;
    repeat (5) @(negedge clk_i);
    oe[2] = moto_o ? ack_oe_n_i : rdy_oe_n_i;
    repeat (30) @(negedge clk_i);
  endtask : access
  // host that ignores the handshake: a fixed 640 ns wait (32 clocks)
  task automatic blind_read(input logic [10:0] addr, output logic [7:0] rd);
    @(negedge clk_i);
    addr_o = addr;
    rw_o = 1'b1;
    sel_n_o = 1'b0;
    @(negedge clk_i);
    strobe_n_o = ~moto_o;
    rd_n_o = moto_o;
    repeat (32) @(negedge clk_i);
    rd = rdata_i;
    {rd_n_o, wr_n_o, strobe_n_o} = 3'h7;
    repeat (5) @(negedge clk_i);
    sel_n_o = 1'b1;
    repeat (30) @(negedge clk_i);
  endtask : blind_read
endmodule : hbw_host_model

// File: sim/tb.sv
// self-checking bench of the host bus wait handshake port
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  errors++; $display("unexpected %s: exp %h got %h", nm, ex, got); end end
module tb import hbw_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, moto, sel_n, rd_n, wr_n, strobe_n, rw;
  logic [10:0] addr, u_addr, q_addr;
  logic [7:0] wdata, rdata, u_wdata, u_rdata, q_wd, rd;
  logic data_oe_n, rdy, rdy_oe_n, ack_n, ack_oe_n, u_req, u_write, q_wr;
  logic u_ack = 1'b0;
  logic [1:0] u_tgt, q_tgt;
  logic [3:0] oe;
  int errors = 0, n_tests = 0, cyc = 0, ack_at = -1, ack_dly = 0, w;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // a long window so that sixteen paced accesses all fall into one
  hbw_host_port #(.FRAME_CLKS_P(2000)) i_dut (
    .CLOCK_I(clk), .RESET_N_I(rst_n), .MOTO_MODE_I(moto), .SEL_N_I(sel_n),
    .RD_N_I(rd_n), .WR_N_I(wr_n), .LOWER_STROBE_N_I(strobe_n), .RW_I(rw),
    .ADDR_I(addr), .DATA_I(wdata), .DATA_O(rdata), .DATA_OE_N_O(data_oe_n),
    .RDY_O(rdy), .RDY_OE_N_O(rdy_oe_n), .DATA_ACK_N_O(ack_n),
    .DATA_ACK_OE_N_O(ack_oe_n), .USR_REQ_O(u_req), .USR_WRITE_O(u_write),
    .USR_TARGET_O(u_tgt), .USR_ADDR_O(u_addr), .USR_WDATA_O(u_wdata),
    .USR_ACK_I(u_ack), .USR_RDATA_I(u_rdata));
  hbw_host_model i_host (
    .clk_i(clk), .moto_o(moto), .sel_n_o(sel_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .strobe_n_o(strobe_n), .rw_o(rw), .addr_o(addr),
    .wdata_o(wdata), .rdata_i(rdata), .data_oe_n_i(data_oe_n), .rdy_i(rdy),
    .rdy_oe_n_i(rdy_oe_n), .ack_n_i(ack_n), .ack_oe_n_i(ack_oe_n));
  // =========================================================================
  // internal target: data follows the address, ack ack_dly after request
  assign u_rdata = addr[7:0] ^ 8'hA5;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (u_req === 1'b1) begin
      ack_at <= cyc + ack_dly + 1;
      q_wr <= u_write;
      q_tgt <= u_tgt;
      q_addr <= u_addr;
      q_wd <= u_wdata;
    end
    if (cyc > 20000) begin
      errors++;
      results();
    end
  end
  always @(negedge clk) u_ack <= (cyc == ack_at);
  // =========================================================================
  // tasks
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("rdy float rst", 1'b1, rdy_oe_n)
    `CHK("ack float rst", 1'b1, ack_oe_n)
    `CHK("data float rst", 1'b1, data_oe_n)
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : do_reset
  task automatic go(input logic wr, input logic [10:0] a, input logic [7:0] d);
    i_host.access(wr, a, d, rd, w, oe);
    `CHK("pin driven", 1'b0, oe[0])
    `CHK("data released", 1'b1, oe[1])
    `CHK("pin floated", 1'b1, oe[2])
    `CHK("data drive", wr, oe[3])
  endtask : go
  task automatic t_intel_reg();
    go(1'b1, 11'h055, 8'h3C);
    `CHK("reg wr wait", 0, w)
    `CHK("reg wr kind", 1'b1, q_wr)
    `CHK("reg wr target", 2'h0, q_tgt)
    `CHK("reg wr addr", 11'h055, q_addr)
    `CHK("reg wr data", 8'h3C, q_wd)
    go(1'b0, 11'h1AA, 8'h00);
    `CHK("reg rd wait", 0, w)
    `CHK("reg rd data", 8'h0F, rd)
    $display("intel register test done");
  endtask : t_intel_reg
  // slow targets; the fifth never acks in time, so it runs to the maximum
  task automatic t_intel_slow();
    logic [10:0] a[6] = '{11'h405, 11'h412, 11'h6F0, 11'h7FF, 11'h4C3, 11'h655};
    int wr[6] = '{1, 0, 1, 0, 1, 0};
    int lo[6] = '{5, 6, 9, 9, 7, 9};
    int hi[6] = '{7, 7, 29, 33, 7, 33};
    int dly[6] = '{0, 0, 0, 0, 40, 40};
    for (int i = 0; i < 6; i++) begin
      ack_dly = dly[i];
      go(wr[i][0], a[i], ~a[i][7:0]);
      `CHK("wait min", 1'b1, w >= SLOW_CYCLE_CLKS * lo[i])
      `CHK("wait max", 1'b1, w <= SLOW_CYCLE_CLKS * hi[i])
      if (wr[i] == 1) begin
        `CHK("slow wr data", ~a[i][7:0], q_wd)
        `CHK("slow target", 2'(a[i][9]) + 2'h1, q_tgt)
      end else `CHK("slow rd data", a[i][7:0] ^ 8'hA5, rd)
    end
    ack_dly = 0;
    $display("intel slow target test done");
  endtask : t_intel_slow
  task automatic t_blind();
    i_host.blind_read(11'h4B1, rd);
    `CHK("blind rd data", 8'h14, rd)
    $display("blind host test done");
  endtask : t_blind
  task automatic t_moto();
    i_host.moto_o = 1'b1;
    repeat (4) @(negedge clk);
    go(1'b1, 11'h033, 8'hC6);
    `CHK("reg wr ack", 1'b1, w < 10)
    `CHK("reg wr data", 8'hC6, q_wd)
    go(1'b0, 11'h144, 8'h00);
    `CHK("reg rd ack", 1'b1, w < 10)
    `CHK("reg rd data", 8'hE1, rd)
    ack_dly = 5;
    go(1'b0, 11'h4A0, 8'h00);
    `CHK("imem rd ack held", 1'b1, w >= 12)
    `CHK("imem rd data", 8'h05, rd)
    go(1'b1, 11'h7A2, 8'h5E);
    `CHK("dram wr ack held", 1'b1, w >= 18)
    `CHK("dram wr data", 8'h5E, q_wd)
    ack_dly = 0;
    i_host.moto_o = 1'b0;
    repeat (4) @(negedge clk);
    $display("motorola test done");
  endtask : t_moto
  // window restarts at reset: sixteen paced accesses, then one too many
  task automatic t_throttle();
    do_reset();
    for (int i = 0; i < 17; i++) begin
      go(1'b1, 11'h600 + 11'(i), 8'(i));
      if (i < 16) `CHK("paced wait", 1'b1, w <= 58)
      else `CHK("throttled wait", SLOW_CYCLE_CLKS * 97, w)
    end
    $display("throttle test done");
  endtask : t_throttle
  initial begin
    do_reset();
    t_intel_reg();
    t_intel_slow();
    t_blind();
    t_moto();
    t_throttle();
    results();
  end
endmodule : tb
